// File: core/cpu_irq_pkg.sv
package cpu_irq_pkg;

    // synchroniser lanes, one per asynchronous pin
    localparam int          SYNC_W   = 4;
    localparam int          IDX_IRQ  = 0;
    localparam int          IDX_NMI  = 1;
    localparam int          IDX_TEST = 2;
    localparam int          IDX_RST  = 3;

    // fixed type of the non-maskable interrupt
    localparam logic [7:0]  NMI_TYPE = 8'h02;
    // table entries are four bytes: address is type times four
    localparam logic [9:0]  VEC_HIGH = 10'h000;
    localparam logic [1:0]  VEC_LOW  = 2'h0;

    // reset values
    localparam logic [7:0]  TYPE_RST = 8'h00;
    localparam logic [19:0] ADDR_RST = 20'h00000;

    typedef enum logic [2:0]
    {
        ST_RUN  = 3'h1,
        ST_RST  = 3'h2,
        ST_IDLE = 3'h4
    } state_t;

    typedef struct packed
    {
        logic instr_last;
        logic if_flag;
        logic wait_exec;
    } core_status_t;

    typedef struct packed
    {
        logic read;
        logic t2;
        logic t3;
        logic tw;
        logic floated;
        logic hold_ack;
    } bus_status_t;

    typedef struct packed
    {
        logic        intack_start;
        logic        vec_fetch;
        logic [7:0]  int_type;
        logic [19:0] vec_addr;
    } irq_req_t;

endpackage

// File: core/cpu_interrupt_reset_inputs.sv
`timescale 1ns/1ps
module cpu_interrupt_reset_inputs
(
    input  wire logic                      clk,
    input  wire logic                      rstn,
    input  wire logic                      maskable_irq_in,
    input  wire logic                      nmi_in,
    input  wire logic                      test_in,
    input  wire logic                      reset_in,
    input  wire logic                      ready_in,
    input  wire cpu_irq_pkg::core_status_t core,
    input  wire cpu_irq_pkg::bus_status_t  bus,
    input  wire logic                      type_valid,
    input  wire logic [7:0]                type_in,
    output cpu_irq_pkg::irq_req_t          irq_out,
    output logic                           core_stall,
    output logic                           core_reset,
    output logic                           restart,
    output logic                           bus_wait,
    output logic                           rd_n,
    output logic                           rd_oe_n
);
    logic [cpu_irq_pkg::SYNC_W-1:0] sync1;
    logic [cpu_irq_pkg::SYNC_W-1:0] sync2;
    logic                           nmi_d;
    logic                           nmi_pend;
    logic                           ack_wait;
    cpu_irq_pkg::state_t            state;

    cpu_irq_pkg::state_t            next_state;
    logic                           next_nmi_pend;
    logic                           next_ack_wait;
    cpu_irq_pkg::irq_req_t          next_irq_out;
    logic                           next_core_stall;
    logic                           next_core_reset;
    logic                           next_restart;
    logic                           next_bus_wait;
    logic                           next_rd_n;
    logic                           next_rd_oe_n;

    logic                           irq_s;
    logic                           test_s;
    logic                           rst_s;
    logic                           nmi_rise;

    assign irq_s    = sync2[cpu_irq_pkg::IDX_IRQ];
    assign test_s   = sync2[cpu_irq_pkg::IDX_TEST];
    assign rst_s    = sync2[cpu_irq_pkg::IDX_RST];
    assign nmi_rise = sync2[cpu_irq_pkg::IDX_NMI] & ~nmi_d;

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            sync1 <= '0;
            sync2 <= '0;
            nmi_d <= 1'b0;
        end
        else
        begin
            sync1 <= {reset_in, test_in, nmi_in, maskable_irq_in};
            sync2 <= sync1;
            nmi_d <= sync2[cpu_irq_pkg::IDX_NMI];
        end
    end

    always_comb
    begin
        next_state      = state;
        next_nmi_pend   = nmi_pend;
        next_ack_wait   = ack_wait;
        next_irq_out    = irq_out;
        next_irq_out.intack_start = 1'b0;
        next_irq_out.vec_fetch    = 1'b0;
        next_core_stall = core_stall;
        next_core_reset = 1'b0;
        next_restart    = 1'b0;
        // ready is used as is; pin timing is the far side's job
        next_bus_wait   = (bus.t3 | bus.tw) & ~ready_in;
        // in T2 strobe low only once the bus has floated; in T3 and TW strobe low whatever floated says
        next_rd_n       = ~(bus.read & ((bus.t2 & bus.floated)
                          | bus.t3 | bus.tw));
        next_rd_oe_n    = bus.hold_ack;
        // edge latched so a short pulse is not lost
        if (nmi_rise)
        begin
            next_nmi_pend = 1'b1;
        end
        case (state)
            cpu_irq_pkg::ST_RUN:
            begin
                // at instruction boundary; waits behind a landing type
                if (core.instr_last && nmi_pend && !(ack_wait && type_valid))
                begin
                    next_nmi_pend             = nmi_rise;
                    next_irq_out.vec_fetch    = 1'b1;
                    next_irq_out.int_type     = cpu_irq_pkg::NMI_TYPE;
                    next_irq_out.vec_addr     = {cpu_irq_pkg::VEC_HIGH,
                        cpu_irq_pkg::NMI_TYPE, cpu_irq_pkg::VEC_LOW};
                end
                // level sampled, gated by enable flag
                else if (core.instr_last && core.if_flag && irq_s
                         && !ack_wait)
                begin
                    next_irq_out.intack_start = 1'b1;
                    next_ack_wait             = 1'b1;
                end
                else if (core.wait_exec && test_s)
                begin
                    next_state      = cpu_irq_pkg::ST_IDLE;
                    next_core_stall = 1'b1;
                end
            end
            cpu_irq_pkg::ST_IDLE:
            begin
                if (!test_s)
                begin
                    next_state      = cpu_irq_pkg::ST_RUN;
                    next_core_stall = 1'b0;
                end
            end
            cpu_irq_pkg::ST_RST:
            begin
                next_core_reset = 1'b1;
                if (!rst_s)
                begin
                    next_state      = cpu_irq_pkg::ST_RUN;
                    next_core_reset = 1'b0;
                    next_restart    = 1'b1;
                end
            end
            default:
            begin
                next_state = cpu_irq_pkg::ST_RST;
            end
        endcase
        // type taken in any state, else the answer is lost
        if (ack_wait && type_valid)
        begin
            next_ack_wait          = 1'b0;
            next_irq_out.vec_fetch = 1'b1;
            next_irq_out.int_type  = type_in;
            next_irq_out.vec_addr  = {cpu_irq_pkg::VEC_HIGH,
                type_in, cpu_irq_pkg::VEC_LOW};
        end
        // high reset overrides everything but rd_oe_n and the held int_type and vec_addr at once
        if (rst_s)
        begin
            next_state                = cpu_irq_pkg::ST_RST;
            next_nmi_pend             = 1'b0;
            next_ack_wait             = 1'b0;
            next_irq_out.intack_start = 1'b0;
            next_irq_out.vec_fetch    = 1'b0;
            next_core_stall           = 1'b0;
            next_core_reset           = 1'b1;
            next_restart              = 1'b0;
            next_bus_wait             = 1'b0;
            next_rd_n                 = 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            state      <= cpu_irq_pkg::ST_RST;
            nmi_pend   <= 1'b0;
            ack_wait   <= 1'b0;
            irq_out    <= {1'b0, 1'b0, cpu_irq_pkg::TYPE_RST,
                           cpu_irq_pkg::ADDR_RST};
            core_stall <= 1'b0;
            core_reset <= 1'b1;
            restart    <= 1'b0;
            bus_wait   <= 1'b0;
            rd_n       <= 1'b1;
            rd_oe_n    <= 1'b1;
        end
        else
        begin
            state      <= next_state;
            nmi_pend   <= next_nmi_pend;
            ack_wait   <= next_ack_wait;
            irq_out    <= next_irq_out;
            core_stall <= next_core_stall;
            core_reset <= next_core_reset;
            restart    <= next_restart;
            bus_wait   <= next_bus_wait;
            rd_n       <= next_rd_n;
            rd_oe_n    <= next_rd_oe_n;
        end
    end

    property p_irq_take;
        @(posedge clk) disable iff (!rstn)
        (state == cpu_irq_pkg::ST_RUN && !rst_s && core.instr_last
         && core.if_flag && irq_s && !nmi_pend && !ack_wait)
        |=> irq_out.intack_start && ack_wait;
    endproperty
    a_irq_take: assert property (p_irq_take)
        else $error("enabled request not acknowledged");
    property p_irq_masked;
        @(posedge clk) disable iff (!rstn)
        !core.if_flag |=> !irq_out.intack_start;
    endproperty
    a_irq_masked: assert property (p_irq_masked)
        else $error("masked request acknowledged");
    property p_irq_sync;
        @(posedge clk) disable iff (!rstn)
        irq_out.intack_start |-> $past(irq_s);
    endproperty
    a_irq_sync: assert property (p_irq_sync)
        else $error("acknowledge without synchronised request");
    property p_test_idle;
        @(posedge clk) disable iff (!rstn)
        (state == cpu_irq_pkg::ST_IDLE && test_s && !rst_s)
        |=> core_stall && state == cpu_irq_pkg::ST_IDLE;
    endproperty
    a_test_idle: assert property (p_test_idle)
        else $error("idle left while test high");
    property p_test_release;
        @(posedge clk) disable iff (!rstn)
        (state == cpu_irq_pkg::ST_IDLE && !test_s && !rst_s)
        |=> !core_stall && state == cpu_irq_pkg::ST_RUN;
    endproperty
    a_test_release: assert property (p_test_release)
        else $error("stall kept after test low");
    property p_nmi_vec;
        @(posedge clk) disable iff (!rstn)
        (state == cpu_irq_pkg::ST_RUN && !rst_s && core.instr_last
         && nmi_pend && !(ack_wait && type_valid))
        |=> irq_out.vec_fetch && irq_out.int_type == 8'h02
            && irq_out.vec_addr == 20'h00008 && !irq_out.intack_start;
    endproperty
    a_nmi_vec: assert property (p_nmi_vec)
        else $error("nmi not serviced as type 2");
    property p_nmi_latch;
        @(posedge clk) disable iff (!rstn)
        (nmi_rise && !rst_s) |=> nmi_pend;
    endproperty
    a_nmi_latch: assert property (p_nmi_latch)
        else $error("nmi edge lost");
    property p_reset_abandon;
        @(posedge clk) disable iff (!rstn)
        rst_s |=> core_reset && !irq_out.vec_fetch && !core_stall
                  && !nmi_pend && rd_n;
    endproperty
    a_reset_abandon: assert property (p_reset_abandon)
        else $error("activity kept under reset");
    property p_restart;
        @(posedge clk) disable iff (!rstn)
        (state == cpu_irq_pkg::ST_RST && !rst_s)
        |=> restart && !core_reset ##1 !restart;
    endproperty
    a_restart: assert property (p_restart)
        else $error("no restart pulse after reset");
    property p_ready;
        @(posedge clk) disable iff (!rstn)
        (!rst_s && (bus.t3 || bus.tw)) |=> bus_wait == !$past(ready_in);
    endproperty
    a_ready: assert property (p_ready)
        else $error("wait state does not follow ready");
    property p_rd_strobe;
        @(posedge clk) disable iff (!rstn)
        (bus.t2 && !bus.floated) |=> rd_n ##0 (rd_oe_n == $past(bus.hold_ack));
    endproperty
    a_rd_strobe: assert property (p_rd_strobe)
        else $error("read strobe early or not floated");
    c_nmi: cover property (@(posedge clk) disable iff (!rstn)
        nmi_rise ##[1:20] irq_out.vec_fetch);
    c_irq: cover property (@(posedge clk) disable iff (!rstn)
        irq_out.intack_start ##[1:20] irq_out.vec_fetch);
    c_idle: cover property (@(posedge clk) disable iff (!rstn)
        core_stall ##[2:20] !core_stall);
    c_reset: cover property (@(posedge clk) disable iff (!rstn)
        restart);
endmodule

// File: testbench/irq_ctrl_model.sv
`timescale 1ns/1ps
module irq_ctrl_model
(
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       ack,
    input  wire logic [3:0] delay,
    input  wire logic [7:0] vec,
    output logic            type_valid,
    output logic [7:0]      type_in
);
    int cnt;

    initial
    begin
        cnt = -1;
        type_valid = 1'b0;
        type_in = 8'h00;
    end

    always @(posedge clk)
    begin
        type_valid <= 1'b0;
        // undriven bus: never repeat the last byte
        type_in <= ~type_in;
        if (!rstn)
            cnt <= -1;
        else if (ack)
            cnt <= delay;
        else if (cnt > 0)
            cnt <= cnt - 1;
        else if (cnt == 0)
        begin
            type_valid <= 1'b1;
            type_in <= vec;
            cnt <= -1;
        end
    end
endmodule

// File: testbench/cpu_interrupt_reset_inputs_tb_top.sv
`timescale 1ns/1ps
module cpu_interrupt_reset_inputs_tb_top;
    logic                      clk, rstn, maskable_irq_in, nmi_in;
    logic                      test_in, reset_in, ready_in, type_valid;
    logic                      core_stall, core_reset, restart;
    logic                      bus_wait, rd_n, rd_oe_n, pr, e;
    logic [7:0]                type_in, vec;
    logic [3:0]                delay;
    logic [2:0]                ev;
    cpu_irq_pkg::core_status_t core;
    cpu_irq_pkg::bus_status_t  bus, pb;
    cpu_irq_pkg::irq_req_t     irq_out;
    int                        n_errors, check_count, seed, r;
    int                        exp_q[$];

    assign ev = {restart, irq_out.vec_fetch, ~core_stall};

    cpu_interrupt_reset_inputs cpu_interrupt_reset_inputs_inst
    (
        .clk, .rstn, .maskable_irq_in, .nmi_in, .test_in, .reset_in,
        .ready_in, .core, .bus, .type_valid, .type_in, .irq_out,
        .core_stall, .core_reset, .restart, .bus_wait, .rd_n, .rd_oe_n
    );

    irq_ctrl_model irq_ctrl_model_inst
    (
        .clk, .rstn, .ack(irq_out.intack_start), .delay, .vec,
        .type_valid, .type_in
    );

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk_vec(input logic [19:0] got, input logic [19:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk_vec({19'h00000, got}, {19'h00000, exp});
    endtask

    task automatic wait_ev(input int k);
        int n;
        for (n = 0; n < 20 && ev[k] !== 1'b1; n++)
            @(negedge clk);
        if (ev[k] !== 1'b1)
        begin
            n_errors++;
            $display("mismatch at %0t: wait %h %h", $time, ev, k);
            end_sim();
        end
    endtask

    task automatic pulse(input cpu_irq_pkg::core_status_t c);
        core <= c;
        @(posedge clk);
        core <= '0;
        @(negedge clk);
    endtask

    task automatic chk_fetch;
        int t;
        t = exp_q.pop_front();
        chk_vec({12'h000, irq_out.int_type}, t[19:0]);
        chk_vec(irq_out.vec_addr, 20'(t * 4));
    endtask

    initial
    begin
        seed = 32'h59F13959;
        n_errors = 0;
        check_count = 0;
        {rstn, maskable_irq_in, nmi_in, test_in, reset_in} = 5'h00;
        ready_in = 1'b1;
        core = '0;
        bus = '0;
        delay = 4'h0;
        vec = 8'h00;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        wait_ev(2);
        chk_bit(core_reset, 1'b0);
        // prompt then slow acknowledge answer
        for (int i = 0; i < 2; i++)
        begin
            @(posedge clk);
            maskable_irq_in <= 1'b1;
            delay <= 4'(i * 5);
            vec <= 8'($random(seed));
            repeat (3) @(posedge clk);
            pulse(3'h4);
            chk_bit(irq_out.intack_start, 1'b0);
            @(posedge clk);
            pulse(3'h6);
            chk_bit(irq_out.intack_start, 1'b1);
            exp_q.push_back(int'(vec));
            @(posedge clk);
            maskable_irq_in <= 1'b0;
            wait_ev(1);
            chk_fetch();
        end
        $display("test maskable done");
        @(posedge clk);
        nmi_in <= 1'b1;
        repeat (4) @(posedge clk);
        // edge gone again before the boundary
        nmi_in <= 1'b0;
        repeat (3) @(posedge clk);
        exp_q.push_back(2);
        pulse(3'h4);
        chk_bit(irq_out.vec_fetch, 1'b1);
        chk_fetch();
        @(posedge clk);
        pulse(3'h4);
        chk_bit(irq_out.vec_fetch, 1'b0);
        $display("test nmi done");
        @(posedge clk);
        test_in <= 1'b1;
        repeat (3) @(posedge clk);
        pulse(3'h1);
        chk_bit(core_stall, 1'b1);
        @(posedge clk);
        reset_in <= 1'b1;
        repeat (5) @(posedge clk);
        reset_in <= 1'b0;
        @(negedge clk);
        chk_bit(core_reset, 1'b1);
        chk_bit(core_stall, 1'b0);
        wait_ev(2);
        chk_bit(core_reset, 1'b0);
        @(posedge clk);
        pulse(3'h1);
        chk_bit(core_stall, 1'b1);
        @(posedge clk);
        test_in <= 1'b0;
        wait_ev(0);
        repeat (2) @(posedge clk);
        pulse(3'h1);
        chk_bit(core_stall, 1'b0);
        $display("test wait and reset done");
        for (int i = 0; i < 200; i++)
        begin
            @(posedge clk);
            r = $random(seed);
            // one bus state at a time, as the sequencer would
            bus <= {r[0], r[2:1] == 2'h1, r[2:1] == 2'h2,
                    r[2:1] == 2'h3, r[3], r[4]};
            // ready changes only on the clock
            ready_in <= r[5];
            @(negedge clk);
            e = ~(pb.read & ((pb.t2 & pb.floated) | pb.t3 | pb.tw));
            if (i > 0)
            begin
                chk_bit(bus_wait, (pb.t3 | pb.tw) & ~pr);
                chk_bit(rd_n, e);
                chk_bit(rd_oe_n, pb.hold_ack);
            end
            pb = bus;
            pr = ready_in;
        end
        $display("test bus done");
        end_sim();
    end
endmodule
